// ### rtl/asi_irq_status.sv
// Sticky event status, enable masks and the host interrupt request
// Assumes every event input comes from logic on i_sys_clk, so no syncs
`include "asi_defines.svh"

// What this block does
// - Starvation event sets converter starvation flag
// - Left clip sticky until converter status read
// - Right clip sticky until converter status read
// - Mute bit live; re-interrupts only on change
// - Converter enable bits 2..0; rest reserved
// - Summary bit 7 on enabled converter event
// - Bit 6 on write during copy
// - Bit 5 on transmit buffer empty, sticky
// - Bit 4 on status block sent, sticky
// - Bit 3 on A/B mismatch, no interrupt
// - Bit 2 on new user block, sticky
// - Bit 1 per block or change, by config
// - Bit 0 on enabled receiver error
// - Summary enables 7..4,2..0; bit 3 reserved
// - Converter status read-only, bits 7..4 zero
// - Each receiver error has its enable bit
module asi_irq_status
	import asi_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire asi_addr_t i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire asi_byte_t i_wr_data,
	output asi_byte_t o_rd_data,
	output logic o_rd_valid,
	input wire logic i_starve_evt,
	input wire logic i_clip_l_evt,
	input wire logic i_clip_r_evt,
	input wire logic i_fast_mode,
	input wire logic i_tx_cs_write,
	input wire logic i_tx_cs_copying,
	input wire logic i_tx_user_empty_evt,
	input wire logic i_tx_cs_done_evt,
	input wire logic i_rx_mismatch_evt,
	input wire logic i_rx_user_new_evt,
	input wire logic i_rx_cs_block_evt,
	input wire logic i_rx_cs_changed_evt,
	input wire logic i_rx_status_change_only_cfg,
	input wire asi_byte_t i_rx_err_pending,
	output logic o_fast_mode_mute_flag,
	output logic o_irq
);

	logic rd_cerr;
	logic rd_sum;
	logic starve_q, starve_d;
	logic clip_l_q, clip_l_d;
	logic clip_r_q, clip_r_d;
	logic fast_q, fast_d;
	logic mute_pend_q, mute_pend_d;
	logic conv_irq;
	logic rx_irq;
	asi_byte_t cerr_status;
	asi_byte_t sum_set;
	asi_byte_t sum_q, sum_d;
	asi_byte_t cerr_en_q, cerr_en_d;
	asi_byte_t sum_en_q, sum_en_d;
	asi_byte_t rx_en_q, rx_en_d;
	asi_byte_t rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;
	logic irq_q, irq_d;

	// Converter flags
	always_comb
	begin
		rd_cerr = i_rd && (i_addr == `ASI_ADDR_CERR_STATUS);
		// A new event in the clearing read's cycle survives the clear
		starve_d = (starve_q && !rd_cerr) || i_starve_evt;
		clip_l_d = (clip_l_q && !rd_cerr) || i_clip_l_evt;
		clip_r_d = (clip_r_q && !rd_cerr) || i_clip_r_evt;
		fast_d = i_fast_mode;
		// Only a change of mode is news; a steady level is quiet after a read
		mute_pend_d = (mute_pend_q && !rd_cerr) ||
			(i_fast_mode != fast_q);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			starve_q <= `ASI_RST_BIT;
			clip_l_q <= `ASI_RST_BIT;
			clip_r_q <= `ASI_RST_BIT;
			fast_q <= `ASI_RST_BIT;
			mute_pend_q <= `ASI_RST_BIT;
		end
		else if (i_ce)
		begin
			starve_q <= starve_d;
			clip_l_q <= clip_l_d;
			clip_r_q <= clip_r_d;
			fast_q <= fast_d;
			mute_pend_q <= mute_pend_d;
		end
	end

	// Visible level for the host's optional output mute
	assign o_fast_mode_mute_flag = fast_q;

	// Summary status
	always_comb
	begin
		rd_sum = i_rd && (i_addr == `ASI_ADDR_SUM_STATUS);
		// Starvation carries no enable, so it never raises the summary
		conv_irq = (clip_l_q && cerr_en_q[`ASI_CERR_CLIP_L]) ||
			(clip_r_q && cerr_en_q[`ASI_CERR_CLIP_R]) ||
			(mute_pend_q && cerr_en_q[`ASI_CERR_MUTE]);
		rx_irq = |(i_rx_err_pending & rx_en_q);
		sum_set = `ASI_RST_BYTE;
		sum_set[`ASI_SUM_CONVERTER] = conv_irq;
		sum_set[`ASI_SUM_TX_COLL] = i_tx_cs_write && i_tx_cs_copying;
		sum_set[`ASI_SUM_TX_USER] = i_tx_user_empty_evt;
		sum_set[`ASI_SUM_TX_DONE] = i_tx_cs_done_evt;
		sum_set[`ASI_SUM_RX_MISMATCH] = i_rx_mismatch_evt;
		sum_set[`ASI_SUM_RX_USER] = i_rx_user_new_evt;
		sum_set[`ASI_SUM_RX_STATUS] = i_rx_status_change_only_cfg ?
			i_rx_cs_changed_evt : i_rx_cs_block_evt;
		sum_set[`ASI_SUM_RECEIVER] = rx_irq;
		sum_d = (sum_q & ~{`ASI_DATA_W{rd_sum}}) | sum_set;
		// Mismatch is masked out by the capable set, never by software
		irq_d = |(sum_q & sum_en_q & `ASI_SUM_IRQ_CAPABLE);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			sum_q <= `ASI_RST_BYTE;
			irq_q <= `ASI_RST_BIT;
		end
		else if (i_ce)
		begin
			sum_q <= sum_d;
			irq_q <= irq_d;
		end
	end

	assign o_irq = irq_q;

	// Enable registers; reserved bits drop on write and read back zero
	always_comb
	begin
		cerr_en_d = cerr_en_q;
		sum_en_d = sum_en_q;
		rx_en_d = rx_en_q;
		if (i_wr)
		begin
			unique case (i_addr)
				`ASI_ADDR_CERR_EN:
					cerr_en_d = i_wr_data & `ASI_CERR_EN_WMASK;
				`ASI_ADDR_SUM_EN:
					sum_en_d = i_wr_data & `ASI_SUM_EN_WMASK;
				`ASI_ADDR_RX_ERR_EN:
					rx_en_d = i_wr_data;
				default:
					cerr_en_d = cerr_en_q;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cerr_en_q <= `ASI_RST_BYTE;
			sum_en_q <= `ASI_RST_BYTE;
			rx_en_q <= `ASI_RST_BYTE;
		end
		else if (i_ce)
		begin
			cerr_en_q <= cerr_en_d;
			sum_en_q <= sum_en_d;
			rx_en_q <= rx_en_d;
		end
	end

	// Read port; data shows the values before the read's own clear
	always_comb
	begin
		cerr_status = `ASI_RST_BYTE;
		cerr_status[`ASI_CERR_STARVE] = starve_q;
		cerr_status[`ASI_CERR_CLIP_L] = clip_l_q;
		cerr_status[`ASI_CERR_CLIP_R] = clip_r_q;
		cerr_status[`ASI_CERR_MUTE] = fast_q;
		rd_valid_d = i_rd;
		rd_data_d = `ASI_RST_BYTE;
		if (i_rd)
		begin
			unique case (i_addr)
				`ASI_ADDR_CERR_STATUS: rd_data_d = cerr_status;
				`ASI_ADDR_CERR_EN: rd_data_d = cerr_en_q;
				`ASI_ADDR_SUM_STATUS: rd_data_d = sum_q;
				`ASI_ADDR_SUM_EN: rd_data_d = sum_en_q;
				`ASI_ADDR_RX_ERR_EN: rd_data_d = rx_en_q;
				default: rd_data_d = `ASI_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rd_data_q <= `ASI_RST_BYTE;
			rd_valid_q <= `ASI_RST_BIT;
		end
		else if (i_ce)
		begin
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign o_rd_data = rd_data_q;
	assign o_rd_valid = rd_valid_q;

	AST_STARVE_SET: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && i_starve_evt) |=> starve_q)
		else $error("starvation event lost");

	AST_CLIP_L_HOLD: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(clip_l_q && !(i_ce && rd_cerr)) |=> clip_l_q)
		else $error("left clip dropped without a read");

	AST_CLIP_R_SET: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && i_clip_r_evt && rd_cerr) |=> clip_r_q)
		else $error("right clip lost to a clearing read");

	AST_MUTE_CHANGE: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && (i_fast_mode != fast_q)) |=> mute_pend_q)
		else $error("mode change raised no pending mute");

	AST_CONV_SUMMARY: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && clip_l_q && cerr_en_q[`ASI_CERR_CLIP_L])
		|=> sum_q[`ASI_SUM_CONVERTER])
		else $error("enabled left clip gave no summary bit");

	AST_COLLISION: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && i_tx_cs_write && i_tx_cs_copying)
		|=> sum_q[`ASI_SUM_TX_COLL])
		else $error("collision not flagged");

	AST_SUM_STICKY: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && !rd_sum) |=> ((sum_q & $past(sum_q)) == $past(sum_q)))
		else $error("status bit cleared without a read");

	AST_RX_STATUS_MODE: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && !i_rx_status_change_only_cfg && i_rx_cs_block_evt)
		|=> sum_q[`ASI_SUM_RX_STATUS])
		else $error("new status block not flagged");

	AST_RECEIVER_SUM: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && |(i_rx_err_pending & rx_en_q))
		|=> sum_q[`ASI_SUM_RECEIVER])
		else $error("enabled receiver error gave no summary");

	AST_MISMATCH_QUIET: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && ((sum_q & sum_en_q & `ASI_SUM_IRQ_CAPABLE) == 8'h00))
		|=> !o_irq)
		else $error("request raised with no enabled bit");

	AST_IRQ_RAISE: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && sum_q[`ASI_SUM_TX_DONE] && sum_en_q[`ASI_SUM_TX_DONE])
		|=> o_irq)
		else $error("enabled status bit raised no request");

	AST_READ_DATA: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(i_ce && rd_cerr) |=> (o_rd_valid && o_rd_data[7:4] == 4'h0 &&
		o_rd_data[`ASI_CERR_CLIP_L] == $past(clip_l_q)))
		else $error("converter status read back wrong");

endmodule // asi_irq_status

// ### shared/asi_defines.svh
// Register offsets, field positions and reset values of the event block
// Assumes a seven-bit register address from the control port decoder
`ifndef ASI_DEFINES_SVH
`define ASI_DEFINES_SVH

`define ASI_ADDR_W 7
`define ASI_DATA_W 8

`define ASI_ADDR_RX_ERR_EN 7'h19
`define ASI_ADDR_CERR_STATUS 7'h1a
`define ASI_ADDR_CERR_EN 7'h1b
`define ASI_ADDR_SUM_STATUS 7'h1c
`define ASI_ADDR_SUM_EN 7'h1d

// Converter error status fields
`define ASI_CERR_STARVE 3
`define ASI_CERR_CLIP_L 2
`define ASI_CERR_CLIP_R 1
`define ASI_CERR_MUTE 0
`define ASI_CERR_EN_WMASK 8'h07

// Summary status fields
`define ASI_SUM_CONVERTER 7
`define ASI_SUM_TX_COLL 6
`define ASI_SUM_TX_USER 5
`define ASI_SUM_TX_DONE 4
`define ASI_SUM_RX_MISMATCH 3
`define ASI_SUM_RX_USER 2
`define ASI_SUM_RX_STATUS 1
`define ASI_SUM_RECEIVER 0
`define ASI_SUM_EN_WMASK 8'hf7
`define ASI_SUM_IRQ_CAPABLE 8'hf7

`define ASI_RST_BYTE 8'h00
`define ASI_RST_BIT 1'b0

`endif

// ### shared/asi_pkg.sv
// Types shared by the event gathering block
// Assumes asi_defines.svh sits on the include path
`include "asi_defines.svh"

package asi_pkg;
	typedef logic [`ASI_DATA_W-1:0] asi_byte_t;
	typedef logic [`ASI_ADDR_W-1:0] asi_addr_t;
endpackage

// ### sim/asi_host_model.sv
// Host model driving the control port of the event block
// Assumes one access per cycle and no wait states on reads
module asi_host_model
	import asi_pkg::*;
(
	input wire logic i_sys_clk,
	input asi_byte_t i_rd_data,
	input wire logic i_rd_valid,
	output logic o_ce,
	output asi_addr_t o_addr,
	output logic o_rd,
	output logic o_wr,
	output asi_byte_t o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Output muting in fast mode is optional and left off here
	initial
	begin
		o_ce = 1'b1;
		o_addr = '0;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wr_data = '0;
	end
	// Released lines show the inverse so stale values cannot pass
	task automatic wr(input asi_addr_t a, input asi_byte_t d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wr_data <= ~d;
	endtask
	task automatic rd(input asi_addr_t a, output asi_byte_t d);
		int n;
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		// The answer stands for only one cycle after the taking edge
		n = 0;
		#1;
		while (i_rd_valid !== 1'b1 && n < 4)
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
	endtask
	task automatic set_ce(input logic v);
		@(posedge i_sys_clk);
		o_ce <= v;
	endtask
endmodule // asi_host_model

// ### sim/tb_audio_src_irq_status_logic.sv
// Self-checking bench for the event status block
// Assumes the host model supplies all control port accesses
module tb_audio_src_irq_status_logic
	import asi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic ce, rd, wr, rvalid, fm, cpy, cfg, irq, mflag;
	asi_addr_t addr;
	asi_byte_t wdata, rdata, pend, d;
	logic [9:0] ev;
	int failures, n_tests, cyc;
	always #2 i_sys_clk = ~i_sys_clk;
	asi_irq_status dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_ce(ce), .i_addr(addr), .i_rd(rd), .i_wr(wr),
		.i_wr_data(wdata), .o_rd_data(rdata), .o_rd_valid(rvalid),
		.i_starve_evt(ev[0]), .i_clip_l_evt(ev[1]), .i_clip_r_evt(ev[2]),
		.i_fast_mode(fm), .i_tx_cs_write(ev[3]), .i_tx_cs_copying(cpy),
		.i_tx_user_empty_evt(ev[4]), .i_tx_cs_done_evt(ev[5]),
		.i_rx_mismatch_evt(ev[6]), .i_rx_user_new_evt(ev[7]),
		.i_rx_cs_block_evt(ev[8]), .i_rx_cs_changed_evt(ev[9]),
		.i_rx_status_change_only_cfg(cfg), .i_rx_err_pending(pend),
		.o_fast_mode_mute_flag(mflag), .o_irq(irq));
	asi_host_model host (.i_sys_clk(i_sys_clk), .i_rd_data(rdata),
		.i_rd_valid(rvalid), .o_ce(ce), .o_addr(addr), .o_rd(rd),
		.o_wr(wr), .o_wr_data(wdata));
	task automatic chk(input string nm, input asi_byte_t e, input asi_byte_t g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic rc(input asi_addr_t a, input asi_byte_t e);
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic pulse(input logic [9:0] v);
		@(posedge i_sys_clk) ev <= v;
		@(posedge i_sys_clk) ev <= '0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic end_sim();
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// The whole run needs a few hundred cycles
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			end_sim();
		end
	end
	initial
	begin
		{ev, fm, cpy, cfg, pend} = '0;
		repeat (16) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		tick(1);
		chkb("irq", 1'b0, irq);
		rc(7'h1b, 8'h00);
		rc(7'h1c, 8'h00);
		rc(7'h1d, 8'h00);
		host.wr(7'h1b, 8'hff);
		rc(7'h1b, 8'h07);
		host.wr(7'h1d, 8'hff);
		rc(7'h1d, 8'hf7);
		host.wr(7'h1a, 8'hff);
		rc(7'h1a, 8'h00);
		rc(7'h7f, 8'h00);
		// A low clock enable must swallow events
		host.set_ce(1'b0);
		pulse(10'h020);
		host.set_ce(1'b1);
		tick(2);
		chkb("irq", 1'b0, irq);
		rc(7'h1c, 8'h00);
		pulse(10'h008);
		tick(2);
		rc(7'h1c, 8'h00);
		@(posedge i_sys_clk) cpy <= 1'b1;
		for (int i = 3; i < 9; i++)
		begin
			pulse(10'h1 << i);
			tick(1);
			chkb("irq", i != 6, irq);
			rc(7'h1c, 8'h80 >> (i - 2));
			tick(1);
			chkb("irq", 1'b0, irq);
			rc(7'h1c, 8'h00);
		end
		host.wr(7'h1d, 8'h00);
		pulse(10'h020);
		tick(2);
		chkb("irq", 1'b0, irq);
		rc(7'h1c, 8'h10);
		host.wr(7'h1d, 8'h80);
		host.wr(7'h1b, 8'h04);
		pulse(10'h004);
		tick(3);
		chkb("irq", 1'b0, irq);
		rc(7'h1a, 8'h02);
		rc(7'h1a, 8'h00);
		pulse(10'h002);
		tick(3);
		chkb("irq", 1'b1, irq);
		rc(7'h1a, 8'h04);
		rc(7'h1c, 8'h80);
		rc(7'h1c, 8'h00);
		pulse(10'h001);
		tick(3);
		chkb("irq", 1'b0, irq);
		rc(7'h1a, 8'h08);
		rc(7'h1a, 8'h00);
		host.wr(7'h1b, 8'h01);
		@(posedge i_sys_clk) fm <= 1'b1;
		tick(4);
		chkb("mute", 1'b1, mflag);
		chkb("irq", 1'b1, irq);
		rc(7'h1a, 8'h01);
		rc(7'h1a, 8'h01);
		rc(7'h1c, 8'h80);
		tick(3);
		chkb("irq", 1'b0, irq);
		@(posedge i_sys_clk) fm <= 1'b0;
		tick(4);
		chkb("mute", 1'b0, mflag);
		chkb("irq", 1'b1, irq);
		rc(7'h1a, 8'h00);
		rc(7'h1c, 8'h80);
		host.wr(7'h1d, 8'h01);
		@(posedge i_sys_clk) pend <= 8'h10;
		tick(3);
		chkb("irq", 1'b0, irq);
		rc(7'h1c, 8'h00);
		host.wr(7'h19, 8'h10);
		rc(7'h19, 8'h10);
		tick(2);
		chkb("irq", 1'b1, irq);
		@(posedge i_sys_clk) pend <= 8'h00;
		tick(3);
		rc(7'h1c, 8'h01);
		rc(7'h1c, 8'h00);
		host.wr(7'h1d, 8'h02);
		@(posedge i_sys_clk) cfg <= 1'b1;
		pulse(10'h100);
		tick(2);
		rc(7'h1c, 8'h00);
		pulse(10'h200);
		tick(2);
		chkb("irq", 1'b1, irq);
		rc(7'h1c, 8'h02);
		end_sim();
	end
endmodule // tb_audio_src_irq_status_logic
